/* crd_pkg.sv */
// Constants, types and state layout for the codec reset and chain discovery block.
// Assumes one 40 MHz master clock and plain-port control access, no register bus.
package crd_pkg;
  localparam int CRD_DISC_PHASE = 64;
  localparam int CRD_DISC_TOTAL = 132;
  localparam int CRD_MAX_DEV = 8;
  localparam int CRD_BYPASS_MAX_DEV = 4;
  localparam int CRD_CNT_W = 8;
  localparam int CRD_SYNC_LAG = 2;
  localparam logic [7:0] CRD_CR1_RST = 8'h00;
  localparam logic [7:0] CRD_CR2_RST = 8'h00;
  localparam logic [7:0] CRD_CR3A_RST = 8'h00;
  localparam int CRD_CR1_DEC_OVF = 7;
  localparam int CRD_CR1_INT_OVF = 4;
  localparam int CRD_CR1_ALOOP = 2;
  localparam int CRD_CR1_DLOOP = 1;
  localparam int CRD_CR2_BYPASS = 6;
  localparam int CRD_CR3A_PD_HI = 5;
  localparam int CRD_CR3A_PD_LO = 4;
  localparam int CRD_CR3A_SWRST = 3;
  localparam logic [7:0] CRD_CR1_WMASK = 8'h6f;

  typedef enum logic [1:0] {CRD_P1, CRD_P2, CRD_TAIL, CRD_RUN} crd_phase_t;

  typedef struct packed {
    logic analog_loop;
    logic digital_loop;
    logic bypass;
    logic rate_x4;
  } crd_route_t;

  typedef struct packed {
    logic adc_down;
    logic dac_down;
    logic analog_down;
    logic full_down;
  } crd_power_t;

  typedef struct packed {
    crd_phase_t phase;
    logic [CRD_CNT_W-1:0] cnt;
    logic [6:0] cnt1;
    logic [6:0] cnt2;
    logic seen1;
    logic seen2;
    logic master;
    logic [3:0] devices;
    logic [3:0] position;
    logic [7:0] cr1;
    logic [7:0] cr2;
    logic [7:0] cr3a;
    logic [1:0] pd_soft;
    logic fs_q;
    logic fsd_q;
    logic fs_s1;
    logic fs_s2;
    logic fsd_s1;
    logic fsd_s2;
    logic pdn_s1;
    logic pdn_s2;
    logic ms_s1;
    logic ms_s2;
  } crd_state_t;
endpackage : crd_pkg

/* crd_reset_chain.sv */
// Reset, chain discovery, loopback, overflow flags, bypass and power-down control.
// Assumes pins frame sync, chained frame output, power-down and master strap are
// asynchronous; overflow events, frame start and control strobes share core_clk_i.
`timescale 1ns/1ps
module crd_reset_chain
  import crd_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic cr1_wr_i,
  input wire logic cr2_wr_i,
  input wire logic cr3a_wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic cr1_rd_i,
  output logic [7:0] cr1_rdata_o,
  output logic [7:0] cr2_rdata_o,
  output logic [7:0] cr3a_rdata_o,
  input wire logic dec_ovf_i,
  input wire logic int_ovf_i,
  input wire logic frame_start_i,
  input wire logic frame_sync_drive_i,
  input wire logic chained_frame_drive_i,
  input wire logic master_sel_i,
  input wire logic powerdown_pin_b_i,
  input wire logic frame_sync_i,
  output logic frame_sync_o,
  output logic frame_sync_oe_o,
  input wire logic chained_frame_output_i,
  output logic chained_frame_output_o,
  output logic chained_frame_output_oe_o,
  output logic init_busy_o,
  output logic [3:0] devices_o,
  output logic [3:0] addr_hi_o,
  output logic bypass_chain_err_o,
  output crd_route_t route_o,
  output crd_power_t power_o
);
  localparam logic [CRD_CNT_W-1:0] P1_END = CRD_CNT_W'(CRD_DISC_PHASE - 1);
  localparam logic [CRD_CNT_W-1:0] P2_END = CRD_CNT_W'(2 * CRD_DISC_PHASE - 1);
  localparam logic [CRD_CNT_W-1:0] INIT_END = CRD_CNT_W'(CRD_DISC_TOTAL - 1);
  localparam logic [3:0] MAX_DEV = 4'(CRD_MAX_DEV);
  localparam logic [3:0] BYP_DEV = 4'(CRD_BYPASS_MAX_DEV);
  localparam logic [6:0] LAG = 7'(CRD_SYNC_LAG);
  localparam crd_state_t RST_VAL = '{
    phase: CRD_P1, cnt: '0, cnt1: '0, cnt2: '0, seen1: 1'b0, seen2: 1'b0,
    master: 1'b0, devices: 4'h1, position: 4'h0, cr1: CRD_CR1_RST,
    cr2: CRD_CR2_RST, cr3a: CRD_CR3A_RST, pd_soft: 2'h0, fs_q: 1'b0,
    fsd_q: 1'b0, fs_s1: 1'b0, fs_s2: 1'b0, fsd_s1: 1'b0, fsd_s2: 1'b0,
    pdn_s1: 1'b1, pdn_s2: 1'b1, ms_s1: 1'b0, ms_s2: 1'b0};

  crd_state_t s;
  crd_state_t next_s;
  logic sw_rst;
  logic [7:0] sum;
  logic [6:0] cnt1_adj;
  logic [6:0] cnt2_adj;
  logic last_slave;

  // Clamp the discovered total into the supported 1..8 range
  function automatic logic [3:0] clamp_dev(input logic [7:0] v);
    if (v == 8'h00) begin
      return 4'h1;
    end
    if (v > 8'(CRD_MAX_DEV)) begin
      return MAX_DEV;
    end
    return v[3:0];
  endfunction : clamp_dev

  assign sw_rst = cr3a_wr_i && wdata_i[CRD_CR3A_SWRST];
  // Each pin pipe shows an edge two clocks late; without this a lone codec would count itself twice
  assign cnt1_adj = (s.cnt1 > LAG) ? s.cnt1 - LAG : 7'h00;
  assign cnt2_adj = (s.cnt2 > LAG) ? s.cnt2 - LAG : 7'h00;
  assign sum = 8'(cnt1_adj) + 8'(cnt2_adj);
  assign last_slave = (s.position == s.devices - 4'h1);

  always_comb begin
    next_s = s;
    next_s.fs_s1 = frame_sync_i;
    next_s.fs_s2 = s.fs_s1;
    next_s.fsd_s1 = chained_frame_output_i;
    next_s.fsd_s2 = s.fsd_s1;
    next_s.pdn_s1 = powerdown_pin_b_i;
    next_s.pdn_s2 = s.pdn_s1;
    next_s.ms_s1 = master_sel_i;
    next_s.ms_s2 = s.ms_s1;
    if (s.phase != CRD_RUN) begin
      next_s.cnt = s.cnt + 1'b1;
    end
    unique case (s.phase)
      CRD_P1: begin
        next_s.master = s.ms_s2;
        if (!s.seen1) begin
          if (s.fsd_s2) begin
            next_s.seen1 = 1'b1;
          end else begin
            next_s.cnt1 = s.cnt1 + 1'b1;
          end
        end
        if (s.cnt == P1_END) begin
          next_s.phase = CRD_P2;
        end
      end
      CRD_P2: begin
        if (!s.seen2) begin
          if (!s.fs_s2) begin
            next_s.seen2 = 1'b1;
          end else begin
            next_s.cnt2 = s.cnt2 + 1'b1;
          end
        end
        if (s.cnt == P2_END) begin
          next_s.phase = CRD_TAIL;
        end
      end
      CRD_TAIL: begin
        next_s.devices = clamp_dev(sum);
        next_s.position = (4'(cnt2_adj) < clamp_dev(sum)) ? 4'(cnt2_adj) : 4'h0;
        if (s.cnt == INIT_END) begin
          next_s.phase = CRD_RUN;
        end
      end
      CRD_RUN: begin
        next_s.fs_q = frame_sync_drive_i;
        next_s.fsd_q = chained_frame_drive_i;
      end
    endcase
    // Loopback and mode bits are plain storage; flag bits are hardware owned
    if (cr1_wr_i) begin
      next_s.cr1 = (wdata_i & CRD_CR1_WMASK) | (s.cr1 & ~CRD_CR1_WMASK);
    end
    if (cr1_rd_i) begin
      next_s.cr1[CRD_CR1_DEC_OVF] = 1'b0;
      next_s.cr1[CRD_CR1_INT_OVF] = 1'b0;
    end
    // Set after clear so an event in the read cycle survives
    if (dec_ovf_i) begin
      next_s.cr1[CRD_CR1_DEC_OVF] = 1'b1;
    end
    if (int_ovf_i) begin
      next_s.cr1[CRD_CR1_INT_OVF] = 1'b1;
    end
    if (cr2_wr_i) begin
      next_s.cr2 = wdata_i;
    end
    if (cr3a_wr_i) begin
      next_s.cr3a = wdata_i;
      next_s.cr3a[CRD_CR3A_SWRST] = 1'b0;
    end
    // Pending soft power-down bits only reach the converters on a frame edge
    if (frame_start_i) begin
      next_s.pd_soft = s.cr3a[CRD_CR3A_PD_HI:CRD_CR3A_PD_LO];
    end
    // Soft reset rebuilds everything but the synchroniser pipes, which stay live
    if (sw_rst) begin
      next_s = RST_VAL;
      next_s.fs_s1 = frame_sync_i;
      next_s.fs_s2 = s.fs_s1;
      next_s.fsd_s1 = chained_frame_output_i;
      next_s.fsd_s2 = s.fsd_s1;
      next_s.pdn_s1 = powerdown_pin_b_i;
      next_s.pdn_s2 = s.pdn_s1;
      next_s.ms_s1 = master_sel_i;
      next_s.ms_s2 = s.ms_s1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s <= RST_VAL;
    end else begin
      s <= next_s;
    end
  end

  always_comb begin
    frame_sync_oe_o = 1'b0;
    chained_frame_output_oe_o = 1'b0;
    frame_sync_o = 1'b0;
    chained_frame_output_o = 1'b0;
    unique case (s.phase)
      CRD_P1: begin
        frame_sync_oe_o = 1'b1;
      end
      CRD_P2: begin
        chained_frame_output_oe_o = 1'b1;
      end
      default: begin
        frame_sync_oe_o = s.master;
        chained_frame_output_oe_o = !last_slave;
        frame_sync_o = s.fs_q;
        chained_frame_output_o = s.fsd_q;
      end
    endcase
  end

  assign init_busy_o = (s.phase != CRD_RUN);
  assign devices_o = s.devices;
  // Two channels per codec, master on top
  assign addr_hi_o = 4'((s.devices << 1) - 4'h1 - (s.position << 1));
  assign bypass_chain_err_o = s.cr2[CRD_CR2_BYPASS] && (s.devices > BYP_DEV);
  assign cr1_rdata_o = s.cr1;
  assign cr2_rdata_o = s.cr2;
  assign cr3a_rdata_o = s.cr3a;
  assign route_o.analog_loop = s.cr1[CRD_CR1_ALOOP];
  assign route_o.digital_loop = s.cr1[CRD_CR1_DLOOP] && !s.cr1[CRD_CR1_ALOOP];
  assign route_o.bypass = s.cr2[CRD_CR2_BYPASS];
  assign route_o.rate_x4 = s.cr2[CRD_CR2_BYPASS];
  // Register contents are untouched by either power-down
  assign power_o.adc_down = s.pd_soft[1] || !s.pdn_s2;
  assign power_o.dac_down = s.pd_soft[0] || !s.pdn_s2;
  assign power_o.analog_down = (&s.pd_soft) || !s.pdn_s2;
  assign power_o.full_down = !s.pdn_s2;

  sequence s_init_run;
    init_busy_o [*8] ##124 init_busy_o ##1 !init_busy_o;
  endsequence

  property p_init_len;
    @(posedge core_clk_i) disable iff (!rst_b_i) sw_rst |=> s_init_run;
  endproperty
  a_init_len: assert property (p_init_len) else $error("init length wrong");

  property p_loop_prio;
    @(posedge core_clk_i) disable iff (!rst_b_i) route_o.analog_loop |-> !route_o.digital_loop;
  endproperty
  a_loop_prio: assert property (p_loop_prio) else $error("digital loop beside analog");

  property p_aloop_wr;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      cr1_wr_i && wdata_i[CRD_CR1_ALOOP] && !sw_rst |=> route_o.analog_loop;
  endproperty
  a_aloop_wr: assert property (p_aloop_wr) else $error("analog loop not set");

  property p_dec_flag;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      dec_ovf_i && !sw_rst |=> cr1_rdata_o[CRD_CR1_DEC_OVF];
  endproperty
  a_dec_flag: assert property (p_dec_flag) else $error("decimation flag lost");

  property p_int_clear;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      cr1_rd_i && !int_ovf_i |=> !cr1_rdata_o[CRD_CR1_INT_OVF];
  endproperty
  a_int_clear: assert property (p_int_clear) else $error("flag not cleared by read");

  property p_flag_hold;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      cr1_rdata_o[CRD_CR1_DEC_OVF] && !cr1_rd_i && !sw_rst |=> cr1_rdata_o[CRD_CR1_DEC_OVF];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped early");

  sequence s_phase1;
    frame_sync_oe_o && !chained_frame_output_oe_o;
  endsequence

  property p_phase1;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      sw_rst |=> s_phase1 [*8] ##57 (!frame_sync_oe_o && chained_frame_output_oe_o);
  endproperty
  a_phase1: assert property (p_phase1) else $error("phase one pin roles wrong");

  property p_phase2;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      sw_rst |=> ##64 (!frame_sync_oe_o && chained_frame_output_oe_o) ##63 chained_frame_output_oe_o;
  endproperty
  a_phase2: assert property (p_phase2) else $error("phase two pin roles wrong");

  property p_master_fs;
    @(posedge core_clk_i) disable iff (!rst_b_i) !init_busy_o && s.master |-> frame_sync_oe_o;
  endproperty
  a_master_fs: assert property (p_master_fs) else $error("master not driving frame sync");

  property p_pd_wait;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      !frame_start_i && !sw_rst && s.pdn_s2 && next_s.pdn_s2 |=> $stable(power_o.adc_down);
  endproperty
  a_pd_wait: assert property (p_pd_wait) else $error("power-down applied off frame");

  property p_hw_pd;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      power_o.full_down |-> power_o.analog_down && power_o.adc_down && power_o.dac_down;
  endproperty
  a_hw_pd: assert property (p_hw_pd) else $error("pin power-down incomplete");
endmodule : crd_reset_chain

/* crd_far_model.sv */
// Far side of the frame sync pins of a stand-alone master codec: the host serial port and the pulled pins.
// Assumes the codec pin drive and enable ports are wired here straight from the block under test.
`timescale 1ns/1ps
module crd_far_model (
  input wire logic fs_drv_i,
  input wire logic fs_oe_i,
  input wire logic fsd_drv_i,
  input wire logic fsd_oe_i,
  output logic fs_pin_o,
  output logic fsd_pin_o
);
  // Last device in the chain: its chained output pin sits on a pull-up when released
  assign fsd_pin_o = fsd_oe_i ? fsd_drv_i : 1'b1;
  // Host keeps its port released during init, so only the pull-down holds the idle wire
  assign fs_pin_o = fs_oe_i ? fs_drv_i : 1'b0;
endmodule : crd_far_model

/* test_codec_reset_chain_discovery.sv */
// Self-checking bench for the reset, chain discovery, loopback, flag, bypass and power-down control.
// Assumes a stand-alone master codec with the far-side pin model beside it.
`timescale 1ns/1ps
module test_codec_reset_chain_discovery;
  import crd_pkg::*;
  logic core_clk_i, rst_b_i, cr1_wr_i, cr2_wr_i, cr3a_wr_i, cr1_rd_i;
  logic [7:0] wdata_i, cr1_q, cr2_q, cr3a_q;
  logic dec_ovf_i, int_ovf_i, frame_start_i, fs_drive, fsd_drive, master_sel, pdn_b;
  logic fs_in, fs_out, fs_oe, fsd_in, fsd_out, fsd_oe, init_busy, chain_err;
  logic [3:0] devices, addr_hi;
  crd_route_t route;
  crd_power_t power;
  int failures = 0;
  int num_checks = 0;

  crd_reset_chain dut_u (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .cr1_wr_i(cr1_wr_i), .cr2_wr_i(cr2_wr_i),
    .cr3a_wr_i(cr3a_wr_i), .wdata_i(wdata_i), .cr1_rd_i(cr1_rd_i), .cr1_rdata_o(cr1_q), .cr2_rdata_o(cr2_q),
    .cr3a_rdata_o(cr3a_q), .dec_ovf_i(dec_ovf_i), .int_ovf_i(int_ovf_i), .frame_start_i(frame_start_i),
    .frame_sync_drive_i(fs_drive), .chained_frame_drive_i(fsd_drive), .master_sel_i(master_sel),
    .powerdown_pin_b_i(pdn_b), .frame_sync_i(fs_in), .frame_sync_o(fs_out), .frame_sync_oe_o(fs_oe),
    .chained_frame_output_i(fsd_in), .chained_frame_output_o(fsd_out), .chained_frame_output_oe_o(fsd_oe),
    .init_busy_o(init_busy), .devices_o(devices), .addr_hi_o(addr_hi), .bypass_chain_err_o(chain_err),
    .route_o(route), .power_o(power));

  crd_far_model far_u (.fs_drv_i(fs_out), .fs_oe_i(fs_oe), .fsd_drv_i(fsd_out), .fsd_oe_i(fsd_oe),
    .fs_pin_o(fs_in), .fsd_pin_o(fsd_in));

  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  task automatic conclude();
    if (failures == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : cyc

  task automatic wr(input int sel, input logic [7:0] d);
    @(posedge core_clk_i);
    wdata_i <= d;
    cr1_wr_i <= (sel == 1);
    cr2_wr_i <= (sel == 2);
    cr3a_wr_i <= (sel == 3);
    @(posedge core_clk_i);
    {cr1_wr_i, cr2_wr_i, cr3a_wr_i} <= 3'b000;
    cyc(1);
  endtask : wr

  // 1 decimation overflow, 2 interpolation overflow, 3 control 1 read, 4 frame start
  task automatic pulse(input int sel);
    @(posedge core_clk_i);
    dec_ovf_i <= (sel == 1);
    int_ovf_i <= (sel == 2);
    cr1_rd_i <= (sel == 3);
    frame_start_i <= (sel == 4);
    @(posedge core_clk_i);
    {dec_ovf_i, int_ovf_i, cr1_rd_i, frame_start_i} <= 4'h0;
    cyc(2);
  endtask : pulse

  // Bounded wait for the end of the init cycle; running out ends the run
  task automatic wait_init(input int limit);
    int i;
    for (i = 0; i < limit && init_busy === 1'b1; i++)
      cyc(1);
    if (init_busy !== 1'b0) begin
      failures++;
      conclude();
    end
  endtask : wait_init

  initial begin
    rst_b_i = 1'b0;
    {cr1_wr_i, cr2_wr_i, cr3a_wr_i, cr1_rd_i} = 4'h0;
    wdata_i = 8'h00;
    {dec_ovf_i, int_ovf_i, frame_start_i, fs_drive, fsd_drive} = 5'h00;
    master_sel = 1'b1;
    pdn_b = 1'b1;
    cyc(2);
    chk({6'h0, fs_oe, init_busy}, 8'h03);
    chk({devices, addr_hi}, 8'h11);
    chk({4'h0, power}, 8'h00);
    // Reset is held seven master clocks, as the host must do after power-up
    cyc(4);
    @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    cyc(21);
    chk({6'h0, fs_oe, fsd_oe}, 8'h02);
    cyc(70);
    chk({6'h0, fs_oe, fsd_oe}, 8'h01);
    cyc(35);
    chk({7'h0, init_busy}, 8'h01);
    wait_init(15);
    chk({4'h0, devices}, 8'h01);
    chk({4'h0, addr_hi}, 8'h01);
    @(posedge core_clk_i);
    fs_drive <= 1'b1;
    cyc(3);
    chk({6'h0, fs_out, fs_oe}, 8'h03);
    chk({6'h0, fsd_oe, fsd_out}, 8'h00);
    for (int k = 1; k <= 3; k++) begin
      wr(1, 8'(k << 1));
      chk(cr1_q, 8'(k << 1));
      chk({4'h0, route}, {4'h0, k[1], k == 1, 2'b00});
    end
    wr(1, 8'hff);
    chk(cr1_q, 8'h6f);
    wr(1, 8'h00);
    pulse(1);
    cyc(4);
    chk(cr1_q, 8'h80);
    pulse(3);
    chk(cr1_q, 8'h00);
    pulse(2);
    cyc(4);
    chk(cr1_q, 8'h10);
    pulse(3);
    chk(cr1_q, 8'h00);
    wr(2, 8'h40);
    chk(cr2_q, 8'h40);
    chk({4'h0, route}, 8'h03);
    chk({7'h0, chain_err}, 8'h00);
    wr(1, 8'h04);
    wr(3, 8'h30);
    chk(cr3a_q, 8'h30);
    chk({4'h0, power}, 8'h00);
    pulse(4);
    chk({4'h0, power}, 8'h0e);
    @(posedge core_clk_i);
    pdn_b <= 1'b0;
    cyc(5);
    chk({4'h0, power}, 8'h0f);
    chk(cr1_q, 8'h04);
    @(posedge core_clk_i);
    pdn_b <= 1'b1;
    cyc(5);
    wr(3, 8'h08);
    chk({cr1_q[3:0], cr2_q[7:4]}, 8'h00);
    chk(cr3a_q, 8'h00);
    chk({3'h0, power, init_busy}, 8'h01);
    wait_init(200);
    chk({4'h0, devices}, 8'h01);
    conclude();
  end
endmodule : test_codec_reset_chain_discovery
